// file: pxc_pkg.sv
package pxc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 50000;
  localparam int unsigned XOVER_HUNT_MS = 60;
  localparam int unsigned XOVER_HUNT_CYCLES = XOVER_HUNT_MS * CLK_FREQ_KHZ;
  localparam int unsigned XOVER_CNT_W = 24;

  // ----------------------------------------------------------------
  // management register map
  // ----------------------------------------------------------------
  localparam int unsigned REG_ADDR_W = 5;
  localparam int unsigned REG_DATA_W = 16;
  localparam int unsigned MGMT_ADDR_W = 5;
  localparam logic [REG_ADDR_W-1:0] EXT_CTRL_TWO_OFS = 5'h13;

  // extended_control_two field positions
  localparam int unsigned ECT_NODE_MODE_BIT = 15;
  localparam int unsigned ECT_SW_MODE_BIT = 14;
  localparam int unsigned ECT_REMOTE_FAULT_BIT = 13;
  localparam int unsigned ECT_XOVER_EN_BIT = 9;
  localparam int unsigned ECT_FORCED_MAP_BIT = 8;
  localparam int unsigned ECT_TRISTATE_BIT = 7;
  localparam int unsigned ECT_AUTO_PWRDN_BIT = 0;

  // reset value and writable bits
  localparam logic [REG_DATA_W-1:0] ECT_RESET_VAL = 16'h4201;
  localparam logic [REG_DATA_W-1:0] ECT_RW_MASK = 16'h1BFF;
  localparam logic ECT_NODE_MODE_VAL = 1'h0;
  localparam logic ECT_SW_MODE_VAL = 1'h1;

  // ----------------------------------------------------------------
  // crossover hunting states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PXC_XS_FORCED = 2'b00,
    PXC_XS_HUNT = 2'b01,
    PXC_XS_LOCKED = 2'b10
  } pxc_xstate_e;
endpackage

// file: pxc_xover.sv
module pxc_xover
  import pxc_pkg::*;
#(
  parameter int unsigned HUNT_CYCLES = XOVER_HUNT_CYCLES
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic auto_en, // pin and register both enable
  input wire logic forced_cross, // forced mapping when auto off
  input wire logic rx_energy, // signal seen on current receive pair
  output logic cross_r // 1 = crossed mapping
);
  // ----------------------------------------------------------------
  // hunting state machine
  // ----------------------------------------------------------------
  pxc_xstate_e state_r, state_nxt;
  logic [XOVER_CNT_W-1:0] cnt_r, cnt_nxt;
  logic cross_nxt;
  wire logic timeout = (cnt_r >= XOVER_CNT_W'(HUNT_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cross_nxt = cross_r;
    unique case (state_r)
      PXC_XS_FORCED: begin
        cross_nxt = forced_cross;
        cnt_nxt = '0;
        if (auto_en) begin
          state_nxt = PXC_XS_HUNT;
        end
      end
      PXC_XS_HUNT: begin
        if (rx_energy) begin
          state_nxt = PXC_XS_LOCKED;
          cnt_nxt = '0;
        end else if (timeout) begin
          cross_nxt = ~cross_r; // try the other pair mapping
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      PXC_XS_LOCKED: begin
        if (rx_energy) begin
          cnt_nxt = '0;
        end else if (timeout) begin
          state_nxt = PXC_XS_HUNT;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = PXC_XS_FORCED;
        cnt_nxt = '0;
      end
    endcase
    if (!auto_en) begin
      state_nxt = PXC_XS_FORCED;
      cross_nxt = forced_cross;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PXC_XS_FORCED;
      cnt_r <= '0;
      cross_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cross_r <= cross_nxt;
    end
  end
endmodule // pxc_xover

// file: pxc_mfpin.sv
module pxc_mfpin
  import pxc_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [MGMT_ADDR_W-1:0] pin_i, // pin levels
  input wire logic [MGMT_ADDR_W-1:0] status, // indicator states, high = asserted
  output logic [MGMT_ADDR_W-1:0] pin_o, // pin drive levels
  output logic [MGMT_ADDR_W-1:0] pin_oe, // pin drive enables
  output logic [MGMT_ADDR_W-1:0] strap_r // captured address
);
  // ----------------------------------------------------------------
  // strap capture at reset release, then indicator drive
  // ----------------------------------------------------------------
  logic sampled_r;
  wire logic [MGMT_ADDR_W-1:0] drive_nxt = status ^ strap_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sampled_r <= 1'b0;
      strap_r <= '0;
      pin_o <= '0;
      pin_oe <= '0;
    end else if (!sampled_r) begin
      sampled_r <= 1'b1;
      strap_r <= pin_i; // first edge after release
    end else begin
      pin_oe <= '1; // outputs from now on
      pin_o <= drive_nxt;
    end
  end
endmodule // pxc_mfpin

// file: pxc_top.sv
// Overview of operation
// - reports software mode; register bits configure device
// - remote fault mirrors partner link fault
// - pin and bit high: auto pair selection
// - bit low: mapping forced by mode bit
// - pin low, bit high: straight mapping
// - straight: A transmits; crossed: B transmits
// - auto on by default, pin pulled up
// - tristate bit floats transmit outputs
// - auto power-down of 100 in 10 mode
// - isolate also powers down 100 transceiver
// - speed indicator high at 100 Mb/s
// - five pins give address then indicators
// - system reset input is active low
// - pins sampled at reset exit, outputs after
// - asserted level inverts the sampled level
module pxc_top
  import pxc_pkg::*;
#(
  parameter int unsigned HUNT_CYCLES = XOVER_HUNT_CYCLES
) (
  input wire logic ref_clk, // system clock
  input wire logic system_reset_low, // async reset, active low
  input wire logic soft_reset, // management software reset pulse
  // management register port
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [pxc_pkg::REG_ADDR_W-1:0] reg_addr, // register index
  input wire logic [pxc_pkg::REG_DATA_W-1:0] reg_wdata, // write data
  output logic [pxc_pkg::REG_DATA_W-1:0] reg_rdata_r, // read data
  output logic reg_rvalid_r, // read data valid pulse
  // device state from the rest of the transceiver
  input wire logic partner_remote_fault, // fault flag from link word
  input wire logic speed_100, // 1 = running at 100 Mb/s
  input wire logic isolate, // basic control isolate bit
  input wire logic rx_energy, // activity seen on receive pair
  input wire logic auto_crossover_enable, // enable pin level
  // line transmit from the transmitter
  input wire logic line_transmit_positive, // transmit data positive
  input wire logic line_transmit_negative, // transmit data negative
  // twisted pair pins
  input wire logic pair_a_positive_i, // pin level
  output logic pair_a_positive_o, // pin drive
  output logic pair_a_positive_oe, // pin enable
  input wire logic pair_a_negative_i, // pin level
  output logic pair_a_negative_o, // pin drive
  output logic pair_a_negative_oe, // pin enable
  input wire logic pair_b_positive_i, // pin level
  output logic pair_b_positive_o, // pin drive
  output logic pair_b_positive_oe, // pin enable
  input wire logic pair_b_negative_i, // pin level
  output logic pair_b_negative_o, // pin drive
  output logic pair_b_negative_oe, // pin enable
  output logic line_receive_positive_r, // selected receive positive
  output logic line_receive_negative_r, // selected receive negative
  // power and speed
  output logic hundred_power_down_r, // 100 Mb/s transceiver off
  output logic speed_indicator_r, // speed indicator pin
  // multi-function pins, bit 4 down to 0
  input wire logic addr4_receive_indicator_i, // pin level
  input wire logic addr3_transmit_indicator_i, // pin level
  input wire logic addr2_link_indicator_i, // pin level
  input wire logic addr1_collision_indicator_i, // pin level
  input wire logic addr0_activity_indicator_i, // pin level
  output logic addr4_receive_indicator_o, // pin drive
  output logic addr3_transmit_indicator_o, // pin drive
  output logic addr2_link_indicator_o, // pin drive
  output logic addr1_collision_indicator_o, // pin drive
  output logic addr0_activity_indicator_o, // pin drive
  output logic addr4_receive_indicator_oe, // pin enable
  output logic addr3_transmit_indicator_oe, // pin enable
  output logic addr2_link_indicator_oe, // pin enable
  output logic addr1_collision_indicator_oe, // pin enable
  output logic addr0_activity_indicator_oe, // pin enable
  input wire logic receive_active, // receive indicator state
  input wire logic transmit_active, // transmit indicator state
  input wire logic link_good, // link indicator state
  input wire logic collision_seen, // collision indicator state
  input wire logic any_activity, // activity indicator state
  output logic [pxc_pkg::MGMT_ADDR_W-1:0] management_address // captured address
);
  import pxc_pkg::*;

  // ----------------------------------------------------------------
  // reset
  // ----------------------------------------------------------------
  wire logic rst_n = system_reset_low;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [REG_DATA_W-1:0] ctrl_r, ctrl_nxt;
  wire logic hit = (reg_addr == EXT_CTRL_TWO_OFS);
  wire logic wr_hit = reg_wr & hit;
  wire logic rd_hit = reg_rd & hit;
  // read-only bits stay at their stored reset value
  wire logic [REG_DATA_W-1:0] wr_merge = (reg_wdata & ECT_RW_MASK) | (ctrl_r & ~ECT_RW_MASK);

  // reserved bits other than bit 10 are stored as written; manager keeps them at default
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (soft_reset) begin
      ctrl_nxt = ECT_RESET_VAL;
    end else if (wr_hit) begin
      ctrl_nxt = wr_merge;
    end
  end

  // live read image
  logic [REG_DATA_W-1:0] rd_image;
  always_comb begin
    rd_image = ctrl_r;
    rd_image[ECT_NODE_MODE_BIT] = ECT_NODE_MODE_VAL;
    rd_image[ECT_SW_MODE_BIT] = ECT_SW_MODE_VAL;
    rd_image[ECT_REMOTE_FAULT_BIT] = partner_remote_fault;
  end
  wire logic [REG_DATA_W-1:0] rdata_nxt = rd_hit ? rd_image : '0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= ECT_RESET_VAL;
      reg_rdata_r <= '0;
      reg_rvalid_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      reg_rdata_r <= rdata_nxt;
      reg_rvalid_r <= reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // field taps
  // ----------------------------------------------------------------
  wire logic xover_bit = ctrl_r[ECT_XOVER_EN_BIT];
  wire logic forced_pair_mapping = ctrl_r[ECT_FORCED_MAP_BIT];
  wire logic pair_tristate_control = ctrl_r[ECT_TRISTATE_BIT];
  wire logic auto_pwrdn = ctrl_r[ECT_AUTO_PWRDN_BIT];

  // ----------------------------------------------------------------
  // crossover selection
  // ----------------------------------------------------------------
  wire logic auto_en = xover_bit & auto_crossover_enable;
  // pin low with bit high forces straight; bit low uses mode bit
  wire logic forced_cross = ~xover_bit & forced_pair_mapping;
  logic cross_r;

  pxc_xover #(
    .HUNT_CYCLES(HUNT_CYCLES)
  ) u_xover (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .auto_en(auto_en),
    .forced_cross(forced_cross),
    .rx_energy(rx_energy),
    .cross_r(cross_r)
  );

  // ----------------------------------------------------------------
  // pair steering
  // ----------------------------------------------------------------
  wire logic drive_en = ~pair_tristate_control;
  wire logic a_oe_nxt = drive_en & ~cross_r;
  wire logic b_oe_nxt = drive_en & cross_r;
  wire logic rxp_nxt = cross_r ? pair_a_positive_i : pair_b_positive_i;
  wire logic rxn_nxt = cross_r ? pair_a_negative_i : pair_b_negative_i;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_a_positive_o <= 1'b0;
      pair_a_negative_o <= 1'b0;
      pair_b_positive_o <= 1'b0;
      pair_b_negative_o <= 1'b0;
      pair_a_positive_oe <= 1'b0;
      pair_a_negative_oe <= 1'b0;
      pair_b_positive_oe <= 1'b0;
      pair_b_negative_oe <= 1'b0;
      line_receive_positive_r <= 1'b0;
      line_receive_negative_r <= 1'b0;
    end else begin
      pair_a_positive_o <= line_transmit_positive;
      pair_a_negative_o <= line_transmit_negative;
      pair_b_positive_o <= line_transmit_positive;
      pair_b_negative_o <= line_transmit_negative;
      pair_a_positive_oe <= a_oe_nxt;
      pair_a_negative_oe <= a_oe_nxt;
      pair_b_positive_oe <= b_oe_nxt;
      pair_b_negative_oe <= b_oe_nxt;
      line_receive_positive_r <= rxp_nxt;
      line_receive_negative_r <= rxn_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power-down and speed indicator
  // ----------------------------------------------------------------
  wire logic pwrdn_nxt = (auto_pwrdn & ~speed_100) | isolate;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hundred_power_down_r <= 1'b0;
      speed_indicator_r <= 1'b0;
    end else begin
      hundred_power_down_r <= pwrdn_nxt;
      speed_indicator_r <= speed_100;
    end
  end

  // ----------------------------------------------------------------
  // multi-function address and indicator pins
  // ----------------------------------------------------------------
  wire logic [MGMT_ADDR_W-1:0] mf_i = {addr4_receive_indicator_i, addr3_transmit_indicator_i,
                                       addr2_link_indicator_i, addr1_collision_indicator_i,
                                       addr0_activity_indicator_i};
  wire logic [MGMT_ADDR_W-1:0] mf_status = {receive_active, transmit_active, link_good,
                                            collision_seen, any_activity};
  logic [MGMT_ADDR_W-1:0] mf_o;
  logic [MGMT_ADDR_W-1:0] mf_oe;

  // soft reset deliberately not connected: pins stay outputs
  pxc_mfpin u_mfpin (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_i(mf_i),
    .status(mf_status),
    .pin_o(mf_o),
    .pin_oe(mf_oe),
    .strap_r(management_address)
  );

  assign {addr4_receive_indicator_o, addr3_transmit_indicator_o, addr2_link_indicator_o,
          addr1_collision_indicator_o, addr0_activity_indicator_o} = mf_o;
  assign {addr4_receive_indicator_oe, addr3_transmit_indicator_oe, addr2_link_indicator_oe,
          addr1_collision_indicator_oe, addr0_activity_indicator_oe} = mf_oe;
endmodule // pxc_top

// file: pxc_top_assertions.sv
module pxc_top_assertions (
  input wire logic ref_clk, // clock
  input wire logic system_reset_low, // reset, active low
  input wire logic reg_rd, // read strobe
  input wire logic [pxc_pkg::REG_ADDR_W-1:0] reg_addr, // index
  input wire logic [pxc_pkg::REG_DATA_W-1:0] reg_rdata_r, // read data
  input wire logic reg_rvalid_r, // read valid
  input wire logic partner_remote_fault, // fault in
  input wire logic speed_100, // speed in
  input wire logic isolate, // isolate in
  input wire logic line_transmit_positive, // tx in
  input wire logic pair_a_positive_o, // pin drive
  input wire logic pair_a_positive_oe, // pin enable
  input wire logic pair_a_negative_oe, // pin enable
  input wire logic pair_b_positive_oe, // pin enable
  input wire logic hundred_power_down_r, // power down
  input wire logic speed_indicator_r, // speed pin
  input wire logic addr4_receive_indicator_oe, // pin enable
  input wire logic addr0_activity_indicator_o, // pin drive
  input wire logic addr0_activity_indicator_oe, // pin enable
  input wire logic any_activity, // indicator state
  input wire logic [pxc_pkg::MGMT_ADDR_W-1:0] management_address // strap
);
  import pxc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!system_reset_low);
  a_read_valid: assert property (system_reset_low && reg_rd |=> reg_rvalid_r)
    else $error("read not answered");
  a_sw_mode: assert property (reg_rd && reg_addr == EXT_CTRL_TWO_OFS
    |=> reg_rdata_r[15:14] == 2'b01) else $error("mode bits wrong");
  a_fault_mirror: assert property (reg_rd && reg_addr == EXT_CTRL_TWO_OFS
    |=> reg_rdata_r[13] == $past(partner_remote_fault)) else $error("fault bit wrong");
  a_one_pair: assert property (pair_a_positive_oe |-> pair_a_negative_oe
    && !pair_b_positive_oe) else $error("both pairs driven");
  a_tx_copy: assert property (pair_a_positive_oe
    |-> pair_a_positive_o == $past(line_transmit_positive)) else $error("tx data wrong");
  a_speed_pin: assert property (system_reset_low
    |=> speed_indicator_r == $past(speed_100)) else $error("speed pin wrong");
  a_isolate_down: assert property (system_reset_low && isolate
    |=> hundred_power_down_r) else $error("isolate not powered down");
  a_fast_no_down: assert property (system_reset_low && speed_100 && !isolate
    |=> !hundred_power_down_r) else $error("power down at 100");
  a_led_inverted: assert property (addr0_activity_indicator_oe
    && $past(addr0_activity_indicator_oe) |-> addr0_activity_indicator_o
    == ($past(any_activity) ^ management_address[0])) else $error("led level wrong");
  a_pin_stays_out: assert property ($past(addr4_receive_indicator_oe)
    |-> addr4_receive_indicator_oe) else $error("pin left output");
  a_strap_held: assert property (addr4_receive_indicator_oe
    |-> $stable(management_address)) else $error("address changed");
endmodule // pxc_top_assertions

bind pxc_top pxc_top_assertions u_chk (.ref_clk, .system_reset_low, .reg_rd, .reg_addr,
  .reg_rdata_r, .reg_rvalid_r, .partner_remote_fault, .speed_100, .isolate,
  .line_transmit_positive, .pair_a_positive_o, .pair_a_positive_oe, .pair_a_negative_oe,
  .pair_b_positive_oe, .hundred_power_down_r, .speed_indicator_r,
  .addr4_receive_indicator_oe, .addr0_activity_indicator_o, .addr0_activity_indicator_oe,
  .any_activity, .management_address);

// file: pxc_sta_model.sv
module pxc_sta_model (
  input wire logic ref_clk, // clock
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [pxc_pkg::REG_ADDR_W-1:0] reg_addr, // index
  output logic [pxc_pkg::REG_DATA_W-1:0] reg_wdata, // write data
  input wire logic [pxc_pkg::REG_DATA_W-1:0] reg_rdata_r, // read data
  input wire logic reg_rvalid_r // read valid
);
  timeunit 1ns;
  timeprecision 1ns;
  import pxc_pkg::*;
  localparam logic [15:0] RSV_MASK = 16'h1C7E;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (d & ~RSV_MASK) | (ECT_RESET_VAL & RSV_MASK);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~reg_wdata;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_r;
    v = reg_rvalid_r;
  endtask
endmodule // pxc_sta_model

// file: pxc_top_test.sv
module pxc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pxc_pkg::*;
  localparam logic [4:0] OFS = EXT_CTRL_TWO_OFS;
  logic ref_clk = 1'b0, system_reset_low = 1'b0, soft_reset = 1'b0, fault = 1'b0;
  logic speed_100 = 1'b0, isolate = 1'b0, rx_energy = 1'b1, xen_pin = 1'b1;
  logic tx_p = 1'b1, tx_n = 1'b0, rx_p = 1'b1, rx_n = 1'b0;
  logic [4:0] status = 5'h00, strap = 5'h15;
  logic [15:0] d;
  logic v, xmap;
  logic [3:0] prev;
  int error_cnt = 0, n_tests = 0, cyc = 0, tog;
  wire reg_wr, reg_rd, rvalid, rx_sel_p, rx_sel_n, pdn, spd_pin;
  wire [4:0] reg_addr, mgmt_addr;
  wire [15:0] reg_wdata, rdata;
  wire [3:0] pr_o, pr_oe, pr_i;
  wire [4:0] mf_o, mf_oe, mf_i;
  // released pins show the far side or the strap resistor
  assign pr_i = (pr_oe & pr_o) | (~pr_oe & {~rx_n, ~rx_p, rx_n, rx_p});
  assign mf_i = (mf_oe & mf_o) | (~mf_oe & strap);
  initial forever #10 ref_clk = ~ref_clk;
  pxc_sta_model sta (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid));
  pxc_top #(.HUNT_CYCLES(16)) dut (.ref_clk(ref_clk), .system_reset_low(system_reset_low),
    .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid),
    .partner_remote_fault(fault), .speed_100(speed_100), .isolate(isolate),
    .rx_energy(rx_energy), .auto_crossover_enable(xen_pin),
    .line_transmit_positive(tx_p), .line_transmit_negative(tx_n),
    .pair_a_positive_i(pr_i[0]), .pair_a_positive_o(pr_o[0]), .pair_a_positive_oe(pr_oe[0]),
    .pair_a_negative_i(pr_i[1]), .pair_a_negative_o(pr_o[1]), .pair_a_negative_oe(pr_oe[1]),
    .pair_b_positive_i(pr_i[2]), .pair_b_positive_o(pr_o[2]), .pair_b_positive_oe(pr_oe[2]),
    .pair_b_negative_i(pr_i[3]), .pair_b_negative_o(pr_o[3]), .pair_b_negative_oe(pr_oe[3]),
    .line_receive_positive_r(rx_sel_p), .line_receive_negative_r(rx_sel_n),
    .hundred_power_down_r(pdn), .speed_indicator_r(spd_pin),
    .addr4_receive_indicator_i(mf_i[4]), .addr3_transmit_indicator_i(mf_i[3]),
    .addr2_link_indicator_i(mf_i[2]), .addr1_collision_indicator_i(mf_i[1]),
    .addr0_activity_indicator_i(mf_i[0]), .addr4_receive_indicator_o(mf_o[4]),
    .addr3_transmit_indicator_o(mf_o[3]), .addr2_link_indicator_o(mf_o[2]),
    .addr1_collision_indicator_o(mf_o[1]), .addr0_activity_indicator_o(mf_o[0]),
    .addr4_receive_indicator_oe(mf_oe[4]), .addr3_transmit_indicator_oe(mf_oe[3]),
    .addr2_link_indicator_oe(mf_oe[2]), .addr1_collision_indicator_oe(mf_oe[1]),
    .addr0_activity_indicator_oe(mf_oe[0]), .receive_active(status[4]),
    .transmit_active(status[3]), .link_good(status[2]), .collision_seen(status[1]),
    .any_activity(status[0]), .management_address(mgmt_addr));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    system_reset_low <= 1'b1;
    settle(3);
    check(mgmt_addr, strap);
    check(mf_oe, 5'h1F);
    check(pr_oe, 4'h3);
    @(posedge ref_clk);
    status <= 5'h0A;
    settle(2);
    check(mf_o, 5'h0A ^ strap);
    sta.rd(OFS, d, v);
    check(v, 1'b1);
    check(d, ECT_RESET_VAL);
    for (int i = 1; i >= 0; i--) begin
      @(posedge ref_clk);
      fault <= i[0];
      sta.rd(OFS, d, v);
      check(d[13], i[0]);
    end
    sta.wr(OFS, 16'hA381);
    settle(3);
    check(pr_oe, 4'h0);
    sta.wr(5'h12, 16'h0000);
    sta.rd(OFS, d, v);
    check(d, 16'h4381);
    sta.rd(5'h12, d, v);
    check(v, 1'b1);
    check(d, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      if (!(i[2] && i[1])) begin
        sta.wr(OFS, {6'h00, i[1], i[0], 8'h01});
        xen_pin <= i[2];
        settle(4);
        xmap = !i[1] && i[0];
        check(pr_oe, xmap ? 4'hC : 4'h3);
        check(pr_o & pr_oe, xmap ? 4'h4 : 4'h1);
        check(rx_sel_p, xmap);
        check(rx_sel_n, !xmap);
      end
    end
    sta.wr(OFS, 16'h0201);
    xen_pin <= 1'b1;
    rx_energy <= 1'b0;
    settle(1);
    tog = 0;
    prev = pr_oe;
    for (int k = 0; k < 60; k++) begin
      settle(1);
      if (pr_oe !== prev) tog++;
      prev = pr_oe;
    end
    check(tog >= 2, 1'b1);
    @(posedge ref_clk);
    rx_energy <= 1'b1;
    settle(3);
    prev = pr_oe;
    settle(50);
    check(pr_oe, prev);
    for (int i = 0; i < 8; i++) begin
      sta.wr(OFS, {15'h0000, i[0]});
      speed_100 <= i[1];
      isolate <= i[2];
      settle(3);
      check(pdn, (i[0] && !i[1]) || i[2]);
      check(spd_pin, i[1]);
    end
    @(posedge ref_clk);
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    sta.rd(OFS, d, v);
    check(d, ECT_RESET_VAL);
    check(mf_oe, 5'h1F);
    @(posedge ref_clk);
    system_reset_low <= 1'b0;
    strap <= 5'h0C;
    settle(2);
    check({mf_oe, pr_oe}, 9'h000);
    @(posedge ref_clk);
    system_reset_low <= 1'b1;
    settle(3);
    check(mgmt_addr, 5'h0C);
    summarize();
  end
endmodule // pxc_top_test
